// File: verilog/mhs_defines.vh
// Constants shared by the memory handshake state machine and its input stage.
// Assumes plain Verilog-2005 inclusion by bare file name from the same folder.
`ifndef MHS_DEFINES_VH
`define MHS_DEFINES_VH

// ----------------------------------------------------------------------------
// State encoding, one-hot, ten states
// ----------------------------------------------------------------------------
`define MHS_ST_W 10
`define MHS_ST_IDLE 10'h001
`define MHS_ST_RD_A 10'h002
`define MHS_ST_RD_B 10'h004
`define MHS_ST_RD_C 10'h008
`define MHS_ST_WR_A 10'h010
`define MHS_ST_DL_A 10'h020
`define MHS_ST_DL_B 10'h040
`define MHS_ST_DL_C 10'h080
`define MHS_ST_WR_B 10'h100
`define MHS_ST_WR_C 10'h200

// ----------------------------------------------------------------------------
// Delay count values shown on the two count outputs
// ----------------------------------------------------------------------------
`define MHS_CNT_ZERO 2'h0
`define MHS_CNT_ONE 2'h1
`define MHS_CNT_TWO 2'h2
`define MHS_CNT_THREE 2'h3

// ----------------------------------------------------------------------------
// Input stage layout: bit positions inside the synchronised pin vector
// ----------------------------------------------------------------------------
`define MHS_PIN_W 7
`define MHS_PIN_REQ 0
`define MHS_PIN_RW 1
`define MHS_PIN_INIT 2
`define MHS_PIN_SEL_A 3
`define MHS_PIN_SEL_B 4
`define MHS_PIN_SEL_C 5
`define MHS_PIN_SEL_D 6
`define MHS_PIN_RESET 7'h00

// Reset level of both synchroniser stages
`define MHS_SYNC_RESET 1'h0

`endif

// File: verilog/mhs_sync.v
// Two-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`include "mhs_defines.vh"

module mhs_sync #(
    parameter WIDTH = `MHS_PIN_W
) (
    // Clock, reset and freeze
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    // Raw levels from outside the clock domain
    input wire [WIDTH-1:0] async_in,
    // Levels safe to use in the core_clk domain
    output wire [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------------
    // One pair of flip-flops per bit
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            reg meta; // First stage, read only by the second stage
            reg safe; // Second stage, the only one the core may read
            // Both stages hold while the clock enable is low
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta <= `MHS_SYNC_RESET;
                    safe <= `MHS_SYNC_RESET;
                end else if (clk_en) begin
                    meta <= async_in[gi];
                    safe <= meta;
                end
            end
            assign sync_out[gi] = safe;
        end
    endgenerate

endmodule

// File: verilog/mhs_top.v
// Memory board handshake controller: answers processor read and write
// transfer requests with data-available and write-complete indications.
// Assumes the processor pins are asynchronous to core_clk and are held
// steady long enough to pass the two-stage input synchroniser.
//
// Function
// R01: Processor starts transfer with request and direction.
// R02: Read: processor samples data, then drops request.
// R03: Write: processor drives data, awaits complete, drops.
// R04: Drive enable and data-available default low.
// R05: Read phases drive, drive+available, then nothing.
// R06: Idle branches to read, write, or stays.
// R07: Read needs request, read, all selects, no init.
// R08: Read phases advance one clock per step.
// R09: Initialise returns every busy state to idle.
// R10: First write phase: strobe on, rest low.
// R11: Delay steps keep strobe, count one-two-three.
// R12: Second write phase strobe+complete; third complete only.
// R13: Write path advances one clock per step.
// R14: Third write phase holds while write persists.
// R15: Third read phase holds until request drops.
`include "mhs_defines.vh"

module mhs_top (
    // Clock, reset and freeze
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    // Processor transfer request pins
    input wire xfer_req,
    input wire read_not_write,
    input wire init_req,
    // Board select address pins
    input wire board_select_a,
    input wire board_select_b,
    input wire board_select_c,
    input wire board_select_d,
    // Read side outputs
    output reg bus_drive_en,
    output reg data_available_flag,
    // Write side outputs
    output reg mem_write_strobe,
    output reg write_complete_flag,
    output reg delay_count_lsb,
    output reg delay_count_msb
);

    // ------------------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------------------
    localparam [`MHS_ST_W-1:0] ST_IDLE = `MHS_ST_IDLE; // Waiting for a request
    localparam [`MHS_ST_W-1:0] ST_RD_A = `MHS_ST_RD_A; // rd_phase_a
    localparam [`MHS_ST_W-1:0] ST_RD_B = `MHS_ST_RD_B; // rd_phase_b
    localparam [`MHS_ST_W-1:0] ST_RD_C = `MHS_ST_RD_C; // rd_phase_c
    localparam [`MHS_ST_W-1:0] ST_WR_A = `MHS_ST_WR_A; // wr_phase_a
    localparam [`MHS_ST_W-1:0] ST_DL_A = `MHS_ST_DL_A; // delay_step_a
    localparam [`MHS_ST_W-1:0] ST_DL_B = `MHS_ST_DL_B; // delay_step_b
    localparam [`MHS_ST_W-1:0] ST_DL_C = `MHS_ST_DL_C; // delay_step_c
    localparam [`MHS_ST_W-1:0] ST_WR_B = `MHS_ST_WR_B; // wr_phase_b
    localparam [`MHS_ST_W-1:0] ST_WR_C = `MHS_ST_WR_C; // wr_phase_c

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    wire [`MHS_PIN_W-1:0] raw_pins; // Pins gathered for the synchroniser
    wire [`MHS_PIN_W-1:0] pins; // Synchronised copy of the pins
    wire req_s; // Synchronised transfer request
    wire rw_s; // Synchronised direction, high for read
    wire init_s; // Synchronised initialise
    wire board_hit; // All four select lines high
    wire rd_start; // Read start condition
    wire wr_start; // Write start condition
    reg [`MHS_ST_W-1:0] state; // Current one-hot state
    reg [`MHS_ST_W-1:0] next_state; // State for the next edge
    reg next_bus_drive_en; // Output values that go with next_state
    reg next_data_available_flag;
    reg next_mem_write_strobe;
    reg next_write_complete_flag;
    reg [1:0] next_delay_count; // {msb, lsb} of the delay count

    // ------------------------------------------------------------------------
    // Input stage
    // ------------------------------------------------------------------------
    // Every pin is asynchronous to core_clk, so all pass two flip-flops.
    // This costs two cycles of latency on each request edge, which the
    // processor absorbs because it waits on the handshake anyway.
    assign raw_pins = {board_select_d, board_select_c, board_select_b,
                       board_select_a, init_req, read_not_write, xfer_req};

    mhs_sync #(
        .WIDTH(`MHS_PIN_W)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(raw_pins),
        .sync_out(pins)
    );

    assign req_s = pins[`MHS_PIN_REQ];
    assign rw_s = pins[`MHS_PIN_RW];
    assign init_s = pins[`MHS_PIN_INIT];
    assign board_hit = pins[`MHS_PIN_SEL_A] & pins[`MHS_PIN_SEL_B] &
                       pins[`MHS_PIN_SEL_C] & pins[`MHS_PIN_SEL_D];

    // ------------------------------------------------------------------------
    // Start conditions
    // ------------------------------------------------------------------------
    // The processor opens a transfer with request plus direction
    assign rd_start = req_s & rw_s & board_hit & ~init_s; // R07 R01
    // Write mirrors the read decode with the direction low
    assign wr_start = req_s & ~rw_s & board_hit & ~init_s; // R01

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    // Initialise is checked first in every busy state so that it wins over
    // any step or hold.
    always @* begin
        next_state = ST_IDLE;
        case (state)
            ST_IDLE: begin
                if (wr_start) begin
                    next_state = ST_WR_A; // R06
                end else if (rd_start) begin
                    next_state = ST_RD_A; // R06
                end else begin
                    next_state = ST_IDLE; // R06
                end
            end
            ST_RD_A: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_RD_B; // R08
                end
            end
            ST_RD_B: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_RD_C; // R08
                end
            end
            ST_RD_C: begin
                // Waits for the processor to lower the request after sampling
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else if (req_s) begin
                    next_state = ST_RD_C; // R15 R02
                end else begin
                    next_state = ST_IDLE; // R15
                end
            end
            ST_WR_A: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_DL_A; // R13
                end
            end
            ST_DL_A: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_DL_B; // R13
                end
            end
            ST_DL_B: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_DL_C; // R13
                end
            end
            ST_DL_C: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_WR_B; // R13
                end
            end
            ST_WR_B: begin
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else begin
                    next_state = ST_WR_C; // R13
                end
            end
            ST_WR_C: begin
                // Holds complete while the write start condition persists
                if (init_s) begin
                    next_state = ST_IDLE; // R09
                end else if (wr_start) begin
                    next_state = ST_WR_C; // R14 R03
                end else begin
                    next_state = ST_IDLE; // R14
                end
            end
            default: begin
                // An illegal code recovers to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Output decode of the next state
    // ------------------------------------------------------------------------
    // Decoding next_state lets the outputs be flip-flops that change on the
    // same edge as the state, with no glitches on the pins.
    always @* begin
        // Everything low unless a state asserts it
        next_bus_drive_en = 1'h0; // R04
        next_data_available_flag = 1'h0; // R04
        next_mem_write_strobe = 1'h0;
        next_write_complete_flag = 1'h0;
        next_delay_count = `MHS_CNT_ZERO;
        case (next_state)
            ST_RD_A: begin
                next_bus_drive_en = 1'h1; // R05
            end
            ST_RD_B: begin
                next_bus_drive_en = 1'h1; // R05
                next_data_available_flag = 1'h1; // R05
            end
            ST_WR_A: begin
                next_mem_write_strobe = 1'h1; // R10
            end
            ST_DL_A: begin
                next_mem_write_strobe = 1'h1; // R11
                next_delay_count = `MHS_CNT_ONE; // R11
            end
            ST_DL_B: begin
                next_mem_write_strobe = 1'h1; // R11
                next_delay_count = `MHS_CNT_TWO; // R11
            end
            ST_DL_C: begin
                next_mem_write_strobe = 1'h1; // R11
                next_delay_count = `MHS_CNT_THREE; // R11
            end
            ST_WR_B: begin
                next_mem_write_strobe = 1'h1; // R12
                next_write_complete_flag = 1'h1; // R12
            end
            ST_WR_C: begin
                next_write_complete_flag = 1'h1; // R12
            end
            default: begin
                // Idle and the third read phase leave every output low
                next_delay_count = `MHS_CNT_ZERO; // R05
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------------------
    // The clock enable freezes state and outputs together, so the pins never
    // disagree with the state they describe.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            bus_drive_en <= 1'h0;
            data_available_flag <= 1'h0;
            mem_write_strobe <= 1'h0;
            write_complete_flag <= 1'h0;
            delay_count_lsb <= 1'h0;
            delay_count_msb <= 1'h0;
        end else if (clk_en) begin
            state <= next_state;
            bus_drive_en <= next_bus_drive_en;
            data_available_flag <= next_data_available_flag;
            mem_write_strobe <= next_mem_write_strobe;
            write_complete_flag <= next_write_complete_flag;
            delay_count_lsb <= next_delay_count[0];
            delay_count_msb <= next_delay_count[1];
        end
    end

endmodule

// File: test/mhs_top_props.sv
// Concurrent checks on the handshake controller's ports.
// Assumes one clock; pins reach the state logic two enabled edges late.
module mhs_top_props (
    // Clock, reset and freeze
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    // Processor pins
    input wire xfer_req,
    input wire read_not_write,
    input wire init_req,
    input wire board_select_a,
    input wire board_select_b,
    input wire board_select_c,
    input wire board_select_d,
    // Answers
    input wire bus_drive_en,
    input wire data_available_flag,
    input wire mem_write_strobe,
    input wire write_complete_flag,
    input wire delay_count_lsb,
    input wire delay_count_msb
);
    // Enabled edges in a row; $past depths count true steps only after four of them
    logic [2:0] en_run;
    wire steady = clk_en && en_run == 3'h4;
    wire sel_all = board_select_a && board_select_b && board_select_c && board_select_d;
    wire [1:0] cnt = {delay_count_msb, delay_count_lsb};
    wire quiet = !bus_drive_en && !data_available_flag && !mem_write_strobe &&
        !write_complete_flag && cnt == 2'h0;
    // Run counter, cleared by a freeze
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) en_run <= 3'h0;
        else if (!clk_en) en_run <= 3'h0;
        else if (en_run != 3'h4) en_run <= en_run + 3'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n || !clk_en);
    drive_excl_a: assert property (bus_drive_en |->
        !mem_write_strobe && !write_complete_flag && cnt == 2'h0)
        else $error("drive with write outputs");
    rd_step_a: assert property (steady && bus_drive_en && !data_available_flag &&
        !$past(init_req, 2) |=> bus_drive_en && data_available_flag)
        else $error("read phase b missed");
    // The edge must be enabled, or the phase is frozen for one more cycle
    rd_drop_a: assert property (clk_en && data_available_flag |=> quiet)
        else $error("read phase c not quiet");
    avail_order_a: assert property ($rose(data_available_flag) |->
        $past(bus_drive_en) && bus_drive_en) else $error("avail without drive");
    rd_start_a: assert property (steady && $rose(bus_drive_en) |->
        $past(xfer_req, 3) && $past(read_not_write, 3) && $past(sel_all, 3) &&
        !$past(init_req, 3)) else $error("bad read start");
    wr_start_a: assert property (steady && $rose(mem_write_strobe) |->
        $past(xfer_req, 3) && !$past(read_not_write, 3) && $past(sel_all, 3) &&
        !$past(init_req, 3) && cnt == 2'h0 && !write_complete_flag)
        else $error("bad write start");
    dly_hold_a: assert property (cnt != 2'h0 |->
        mem_write_strobe && !write_complete_flag && !bus_drive_en)
        else $error("delay outputs wrong");
    wr_seq_a: assert property (steady && mem_write_strobe && !write_complete_flag &&
        cnt == 2'h0 && !init_req && !$past(init_req) && !$past(init_req, 2) |=>
        cnt == 2'h1 ##1 cnt == 2'h2 ##1 (mem_write_strobe && cnt == 2'h3))
        else $error("delay count order");
    wr_tail_a: assert property (steady && cnt == 2'h3 && !$past(init_req) &&
        !$past(init_req, 2) |=> (mem_write_strobe && write_complete_flag && cnt == 2'h0)
        ##1 (!mem_write_strobe && write_complete_flag)) else $error("write tail wrong");
    wr_hold_a: assert property (steady && !mem_write_strobe && write_complete_flag &&
        $past(xfer_req, 2) && !$past(read_not_write, 2) && $past(sel_all, 2) &&
        !$past(init_req, 2) |=> !mem_write_strobe && write_complete_flag)
        else $error("write phase c left");
    wr_leave_a: assert property (steady && write_complete_flag && !mem_write_strobe &&
        !$past(xfer_req, 2) |=> quiet) else $error("write phase c stuck");
    init_idle_a: assert property (steady && init_req |-> ##3 quiet)
        else $error("init did not idle");
endmodule
bind mhs_top mhs_top_props u_mhs_top_props (.core_clk, .reset_n, .clk_en, .xfer_req,
    .read_not_write, .init_req, .board_select_a, .board_select_b, .board_select_c,
    .board_select_d, .bus_drive_en, .data_available_flag, .mem_write_strobe,
    .write_complete_flag, .delay_count_lsb, .delay_count_msb);

// File: test/mhs_cpu_model.sv
// Processor side: raises a request, waits for the answer, then drops it.
// Assumes answers are registered on the rising edge of core_clk.
module mhs_cpu_model (
    // Clock
    input wire logic core_clk,
    // Answers
    input wire logic data_available_flag,
    input wire logic write_complete_flag,
    // Request pins
    output logic xfer_req,
    output logic read_not_write,
    output logic board_select_a,
    output logic board_select_b,
    output logic board_select_c,
    output logic board_select_d
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        xfer_req = 1'b0;
        {read_not_write, board_select_d, board_select_c, board_select_b, board_select_a} = 5'h00;
    end
    // One transfer; the wait is bounded since a deselected board never answers
    task automatic transfer(input logic rd, input logic [3:0] sel, input int stall,
        output logic got);
        int n;
        got = 1'b0;
        n = 0;
        @(posedge core_clk);
        xfer_req <= 1'b1;
        read_not_write <= rd;
        {board_select_d, board_select_c, board_select_b, board_select_a} <= sel;
        while (got !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
            got = rd ? data_available_flag : write_complete_flag;
        end
        repeat (stall + 1) @(posedge core_clk);
        xfer_req <= 1'b0;
        // Released lines wander so nothing leans on stale levels
        {read_not_write, board_select_d, board_select_c, board_select_b, board_select_a} <=
            5'($urandom);
        // Stay released long enough for the drop to pass the input stage
        repeat (2) @(posedge core_clk);
    endtask
endmodule

// File: test/mhs_top_test.sv
// Self-checking bench: a cycle model with a pin queue is compared each edge.
// Assumes mhs_top, its checker and the processor model; 40 MHz clock.
module mhs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic init_req = 1'b0;
    logic got, done;
    wire xfer_req, read_not_write, board_select_a, board_select_b, board_select_c, board_select_d;
    wire bus_drive_en, data_available_flag, mem_write_strobe, write_complete_flag;
    wire delay_count_lsb, delay_count_msb;
    int error_cnt = 0;
    int check_count = 0;
    int st = 0;
    logic [6:0] pq[$] = '{7'h00, 7'h00};
    logic [6:0] p;
    logic r, w;
    // Observed outputs in the order of out_tab
    wire [5:0] outs = {bus_drive_en, data_available_flag, mem_write_strobe,
        write_complete_flag, delay_count_msb, delay_count_lsb};
    // Outputs per state {drive, avail, strobe, complete, msb, lsb}
    localparam logic [5:0] out_tab [10] = '{6'h00, 6'h20, 6'h30, 6'h00, 6'h08, 6'h09,
        6'h0a, 6'h0b, 6'h0c, 6'h04};
    mhs_top u_mhs_top (.core_clk, .reset_n, .clk_en, .xfer_req, .read_not_write, .init_req,
        .board_select_a, .board_select_b, .board_select_c, .board_select_d, .bus_drive_en,
        .data_available_flag, .mem_write_strobe, .write_complete_flag, .delay_count_lsb,
        .delay_count_msb);
    mhs_cpu_model u_mhs_cpu_model (.core_clk, .data_available_flag, .write_complete_flag,
        .xfer_req, .read_not_write, .board_select_a, .board_select_b, .board_select_c,
        .board_select_d);
    initial forever #12.5 core_clk = ~core_clk;
    task check(input string what, input logic [5:0] seen, input logic [5:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Reference: two-deep queue for the synchroniser, integer state index
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pq = '{7'h00, 7'h00};
            st = 0;
        end else begin
            check("outputs", outs, out_tab[st]);
            if (clk_en) begin
                p = pq.pop_front();
                pq.push_back({board_select_d, board_select_c, board_select_b, board_select_a,
                    init_req, read_not_write, xfer_req});
                r = p[0] & p[1] & (&p[6:3]) & !p[2];
                w = p[0] & !p[1] & (&p[6:3]) & !p[2];
                if (p[2] && st != 0) st = 0;
                else case (st)
                    0: st = w ? 4 : (r ? 1 : 0);
                    3: st = p[0] ? 3 : 0;
                    9: st = w ? 9 : 0;
                    default: st = st + 1;
                endcase
            end
        end
    end
    // A transfer that must answer exactly when fully selected
    task xfer(input logic rd, input logic [3:0] sel, input int stall);
        u_mhs_cpu_model.transfer(rd, sel, stall, got);
        check("answer", {5'h00, got}, {5'h00, &sel});
    endtask
    // Hang guard
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(80));
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        // Prompt and slow reads and writes
        for (int i = 0; i < 6; i++) xfer(i[0], 4'hf, i);
        // Every partial select is ignored
        for (int s = 0; s < 15; s++) xfer(1'($urandom), s[3:0], 0);
        // Initialise lands in each busy state of both paths
        for (int k = 1; k < 21; k++) begin
            fork
                u_mhs_cpu_model.transfer(k[0], 4'hf, 0, got);
                begin
                    repeat (k / 2 + 1) @(posedge core_clk);
                    init_req <= 1'b1;
                    @(posedge core_clk);
                    init_req <= 1'b0;
                end
            join
            check("init answer", {5'h00, got}, 6'h01);
        end
        // Initialise held high blocks a start from idle
        fork
            u_mhs_cpu_model.transfer(1'b1, 4'hf, 0, got);
            begin
                init_req <= 1'b1;
                repeat (10) @(posedge core_clk);
                init_req <= 1'b0;
            end
        join
        check("held init answer", {5'h00, got}, 6'h01);
        // Reset in mid write
        fork
            u_mhs_cpu_model.transfer(1'b0, 4'hf, 0, got);
            begin
                repeat (6) @(posedge core_clk);
                reset_n <= 1'b0;
                repeat (2) @(posedge core_clk);
                reset_n <= 1'b1;
            end
        join
        check("reset answer", {5'h00, got}, 6'h01);
        // Random back-to-back traffic with the clock enable dropping
        done = 1'b0;
        fork
            begin
                repeat (30) xfer(1'($urandom), 4'hf, $urandom_range(0, 3));
                done = 1'b1;
            end
            while (!done) begin
                @(posedge core_clk);
                // Never two frozen edges in a row, so a short request drop is seen
                clk_en <= !clk_en || ($urandom_range(0, 3) != 0);
            end
        join
        @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (5) @(posedge core_clk);
        tally_and_finish;
    end
endmodule
